// file: shared/ccd_pkg.sv
// shared constants and types for the ccd timing and converter setup block
package ccd_pkg;

  // clocking; the pixel rate is the system clock divided by eight
  localparam int          SYS_CLK_HZ     = 100_000_000;
  localparam int          PIX_MAX_HZ     = 6_000_000;
  localparam logic [3:0]  PIX_DIV        = 4'h8;
  localparam logic [3:0]  PIX_HALF       = 4'h4;

  // fixed sensor timing, in lines and pixel counts
  localparam logic [12:0] FLUSH_LINES    = 13'hfa0;
  localparam logic [6:0]  V_WIDTH_PIX    = 7'h40;

  // integration base
  localparam int          INT_CLK_HZ     = 100;
  localparam int          UNIT_INT_MS    = 10;

  // three-wire serial link; half period rounds up so the clock never
  // runs faster than its maximum
  localparam int          SER_CLK_MAX_HZ = 10_000_000;
  localparam int          SER_HALF_INT   =
    (SYS_CLK_HZ + 2 * SER_CLK_MAX_HZ - 1) / (2 * SER_CLK_MAX_HZ);
  localparam logic [3:0]  SER_HALF_CYC   = SER_HALF_INT[3:0];
  localparam logic [4:0]  SER_BITS       = 5'h10;
  localparam logic        SER_RW_WRITE   = 1'b0;

  // converter register map
  localparam int          NUM_REGS       = 8;
  localparam logic [2:0]  ADR_CFG        = 3'h0;
  localparam logic [2:0]  ADR_MUX        = 3'h1;
  localparam logic [2:0]  ADR_GAIN_R     = 3'h2;
  localparam logic [2:0]  ADR_GAIN_G     = 3'h3;
  localparam logic [2:0]  ADR_GAIN_B     = 3'h4;
  localparam logic [2:0]  ADR_OFS_R      = 3'h5;
  localparam logic [2:0]  ADR_OFS_G      = 3'h6;
  localparam logic [2:0]  ADR_OFS_B      = 3'h7;

  // configuration fields
  localparam int          CFG_CDS_BIT    = 5;
  localparam int          CFG_SPAN3_BIT  = 4;
  localparam int          CFG_SPAN15_BIT = 3;
  localparam int          CFG_CH3_BIT    = 2;
  localparam int          CFG_CH1_BIT    = 1;
  localparam logic [7:0]  CFG_ZERO_MASK  = 8'hc1;

  // mux fields
  localparam int          MUX_GREEN_BIT  = 3;
  localparam int          MUX_FIXED1_BIT = 0;

  // power-up values: cds, 3 v span, one channel; green selected
  localparam logic [7:0]  CFG_DEFAULT    = 8'h32;
  localparam logic [7:0]  MUX_DEFAULT    = 8'h09;
  localparam logic [7:0]  GAIN_DEFAULT   = 8'h00;
  localparam logic [7:0]  OFS_DEFAULT    = 8'h00;
  localparam logic [63:0] REG_DEFAULTS   = {OFS_DEFAULT, OFS_DEFAULT,
                                            OFS_DEFAULT, GAIN_DEFAULT,
                                            GAIN_DEFAULT, GAIN_DEFAULT,
                                            MUX_DEFAULT, CFG_DEFAULT};

  // one serial register write
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } ccd_wr_t;

endpackage

// file: src/ccd_ser_wr.sv
// three-wire serial writer for the converter registers
`timescale 1ns/10ps
module ccd_ser_wr (
  // clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  // write request
  input  wire logic            req_valid_i,
  input  wire ccd_pkg::ccd_wr_t req_i,
  output logic                 req_ready_o,
  // serial pins
  output logic                 sclk_o,
  output logic                 sdata_o,
  output logic                 sload_n_o
);

  logic        busy_q;
  logic        phase_q;
  logic [3:0]  div_q;
  logic [4:0]  bit_q;
  logic [15:0] sh_q;

  assign req_ready_o = ~busy_q;

  // frame: write flag, address, four idle bits, data; msb first
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_q  <= 1'b0;
      phase_q <= 1'b0;
      div_q   <= 4'h0;
      bit_q   <= 5'h00;
      sh_q    <= 16'h0000;
    end else if (!busy_q) begin
      if (req_valid_i) begin
        busy_q  <= 1'b1;
        phase_q <= 1'b0;
        div_q   <= 4'h0;
        bit_q   <= 5'h00;
        sh_q    <= {ccd_pkg::SER_RW_WRITE, req_i.addr, 4'h0, req_i.data};
      end
    end else if (div_q == ccd_pkg::SER_HALF_CYC - 4'h1) begin
      div_q   <= 4'h0;
      phase_q <= ~phase_q;
      // data moves after the rising edge so it is stable around it
      if (phase_q) begin
        sh_q <= {sh_q[14:0], 1'b0};
        if (bit_q == ccd_pkg::SER_BITS - 5'h01) begin
          busy_q <= 1'b0;
        end else begin
          bit_q <= bit_q + 5'h01;
        end
      end
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign sclk_o    = phase_q;
  assign sdata_o   = sh_q[15];
  assign sload_n_o = ~busy_q;

endmodule // ccd_ser_wr

// file: src/ccd_line_tmr.sv
// pixel divider and line timer
`timescale 1ns/10ps
module ccd_line_tmr #(
  parameter int LW = 13
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  // control
  input  wire logic          run_i,
  input  wire logic [LW-1:0] pix_per_line_i,
  // timing
  output logic               pix_tick_o,
  output logic               line_end_o,
  output logic               v_active_o,
  output logic               h_first_o
);

  logic [3:0]    div_q;
  logic [LW-1:0] pix_q;
  logic [LW-1:0] line_len;

  // line is the vertical pulse followed by the pixels
  assign line_len   = LW'(ccd_pkg::V_WIDTH_PIX) + pix_per_line_i;
  assign pix_tick_o = run_i && (div_q == ccd_pkg::PIX_DIV - 4'h1);
  assign line_end_o = pix_tick_o && (pix_q >= line_len - LW'(1));
  assign v_active_o = run_i && (pix_q < LW'(ccd_pkg::V_WIDTH_PIX));
  assign h_first_o  = div_q < ccd_pkg::PIX_HALF;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run_i) begin
      div_q <= 4'h0;
    end else if (pix_tick_o) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run_i) begin
      pix_q <= '0;
    end else if (line_end_o) begin
      pix_q <= '0;
    end else if (pix_tick_o) begin
      pix_q <= pix_q + LW'(1);
    end
  end

endmodule // ccd_line_tmr

// file: src/ccd_timing_top.sv
// sensor clocking sequencer and converter register loader
// Function
// - the pixel period is eight system clock cycles.
// - pixel rates up to 6 MHz are supported, with the system clock at 8x.
// - a flush clocks out 4000 line periods whatever the sensor geometry.
// - the vertical transfer pulse lasts 64 pixel counts.
// - integration ends on the int_units_i-th integration clock rise; zero units gives one cycle.
// - config byte has bits 7, 6, 0 zero and holds cds, span, channel mode.
// - registers 2 to 4 hold the red, green and blue gain codes.
// - registers 5 to 7 hold sign-magnitude red, green, blue offset codes.
// - with internal programming all eight registers load after power-up.
// - in still mode a trigger fall runs flush, integrate, one frame, wait.
// - in free-run mode frames repeat with no flush phase.
`timescale 1ns/10ps
module ccd_timing_top #(
  parameter int LW = 13
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  // mode and geometry
  input  wire logic          still_mode_i,
  input  wire logic          acquire_n_i,
  input  wire logic          int_clk_i,
  input  wire logic [5:0]    int_units_i,
  input  wire logic [LW-1:0] pix_per_line_i,
  input  wire logic [LW-1:0] lines_per_frame_i,
  // converter programming
  input  wire logic          prog_internal_i,
  input  wire logic [2:0]    adj_addr_i,
  input  wire logic [7:0]    adj_data_i,
  // sensor and sync outputs
  output logic [1:0]         vertical_phase_clocks_o,
  output logic [1:0]         horizontal_phase_clocks_o,
  output logic               pix_sync_o,
  output logic               line_sync_o,
  output logic               frame_sync_o,
  output logic               integrate_o,
  output logic               flushing_o,
  // converter serial link
  output logic               ser_clk_o,
  output logic               ser_data_o,
  output logic               ser_load_n_o,
  output logic               adc_busy_o
);

  typedef enum {ST_IDLE, ST_FLUSH, ST_INTEG, ST_READ} ccd_state_t;

  ccd_state_t       st_q;
  logic [LW-1:0]    line_cnt_q;
  logic [5:0]       int_cnt_q;
  logic             acq_q;
  logic             intclk_q;
  logic             boot_q;
  logic             acq_fall;
  logic             int_tick;
  logic             run;
  logic             pix_tick;
  logic             line_end;
  logic             v_active;
  logic             h_first;
  logic [7:0]       shadow_q [ccd_pkg::NUM_REGS];
  logic [7:0]       pend_q;
  logic [7:0]       pend_d;
  logic [2:0]       sel;
  logic             req_valid;
  logic             req_ready;
  ccd_pkg::ccd_wr_t req;

  // the trigger is active low; only its falling edge counts
  assign acq_fall = acq_q && !acquire_n_i;
  assign int_tick = int_clk_i && !intclk_q;
  assign run      = (st_q == ST_FLUSH) || (st_q == ST_READ);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      acq_q    <= 1'b1;
      intclk_q <= 1'b0;
    end else begin
      acq_q    <= acquire_n_i;
      intclk_q <= int_clk_i;
    end
  end

  // rate limit: pixel rate tracks the system clock, no other divider
  ccd_line_tmr #(
    .LW (LW)
  ) u_line (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .run_i          (run),
    .pix_per_line_i (pix_per_line_i),
    .pix_tick_o     (pix_tick),
    .line_end_o     (line_end),
    .v_active_o     (v_active),
    .h_first_o      (h_first)
  );

  // acquisition sequencer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q       <= ST_IDLE;
      line_cnt_q <= '0;
      int_cnt_q  <= 6'h00;
    end else begin
      case (st_q)
        ST_IDLE: begin
          line_cnt_q <= '0;
          int_cnt_q  <= 6'h00;
          if (!still_mode_i) begin
            st_q <= ST_INTEG;
          end else if (acq_fall) begin
            st_q <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          if (line_end) begin
            if (line_cnt_q == LW'(ccd_pkg::FLUSH_LINES) - LW'(1)) begin
              st_q       <= ST_INTEG;
              line_cnt_q <= '0;
            end else begin
              line_cnt_q <= line_cnt_q + LW'(1);
            end
          end
        end
        ST_INTEG: begin
          // zero units means no exposure beyond the flush
          if (int_units_i == 6'h00) begin
            st_q      <= ST_READ;
            int_cnt_q <= 6'h00;
          end else if (int_tick) begin
            if (int_cnt_q >= int_units_i - 6'h01) begin
              st_q      <= ST_READ;
              int_cnt_q <= 6'h00;
            end else begin
              int_cnt_q <= int_cnt_q + 6'h01;
            end
          end
        end
        ST_READ: begin
          if (line_end) begin
            if (line_cnt_q + LW'(1) >= lines_per_frame_i) begin
              line_cnt_q <= '0;
              // a mode change takes effect only at a frame boundary
              st_q <= still_mode_i ? ST_IDLE : ST_INTEG;
            end else begin
              line_cnt_q <= line_cnt_q + LW'(1);
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // registered sensor clocks and syncs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      vertical_phase_clocks_o   <= 2'h0;
      horizontal_phase_clocks_o <= 2'h0;
      pix_sync_o                <= 1'b0;
      line_sync_o               <= 1'b0;
      frame_sync_o              <= 1'b0;
      integrate_o               <= 1'b0;
      flushing_o                <= 1'b0;
    end else begin
      vertical_phase_clocks_o   <= {v_active, 1'b0} | {1'b0, run && !v_active};
      horizontal_phase_clocks_o <= (run && !v_active) ?
                                   {h_first, !h_first} : 2'h0;
      pix_sync_o                <= pix_tick && (st_q == ST_READ) && !v_active;
      line_sync_o               <= (st_q == ST_READ) && !v_active;
      frame_sync_o              <= st_q == ST_READ;
      integrate_o               <= st_q == ST_INTEG;
      flushing_o                <= st_q == ST_FLUSH;
    end
  end

  // one flop per boot; strap is looked at only after reset release
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      boot_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
    end
  end

  // shadow copy of the converter registers, one entry per address
  for (genvar g = 0; g < ccd_pkg::NUM_REGS; g++) begin : g_shadow
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        shadow_q[g] <= ccd_pkg::REG_DEFAULTS[g*8 +: 8];
      end else if (prog_internal_i && acq_fall && adj_addr_i == 3'(g)) begin
        // test bits of the config byte are forced low
        if (3'(g) == ccd_pkg::ADR_CFG) begin
          shadow_q[g] <= adj_data_i & ~ccd_pkg::CFG_ZERO_MASK;
        end else begin
          shadow_q[g] <= adj_data_i;
        end
      end
    end
  end

  // lowest pending address goes first
  always_comb begin
    sel = 3'h0;
    for (int i = ccd_pkg::NUM_REGS - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        sel = 3'(i);
      end
    end
  end

  assign req_valid = |pend_q;
  assign req.addr  = sel;
  assign req.data  = shadow_q[sel];

  // new request for an address wins over the clear of its pending bit
  always_comb begin
    pend_d = pend_q;
    if (req_valid && req_ready) begin
      pend_d[sel] = 1'b0;
    end
    if (!boot_q && prog_internal_i) begin
      pend_d = 8'hff;
    end
    if (prog_internal_i && acq_fall) begin
      pend_d[adj_addr_i] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pend_q <= 8'h00;
    end else begin
      pend_q <= pend_d;
    end
  end

  ccd_ser_wr u_ser (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .req_valid_i (req_valid),
    .req_i       (req),
    .req_ready_o (req_ready),
    .sclk_o      (ser_clk_o),
    .sdata_o     (ser_data_o),
    .sload_n_o   (ser_load_n_o)
  );

  assign adc_busy_o = req_valid || !req_ready;

endmodule // ccd_timing_top

// file: verif/ccd_adc_model.sv
// behavioural model of the serially programmed converter registers
`timescale 1ns/10ps
module ccd_adc_model (
  // serial pins from the block
  input  wire logic        ser_clk_i,
  input  wire logic        ser_data_i,
  input  wire logic        ser_load_n_i,
  // register image for the bench
  output logic [63:0]      regs_o
);
  logic [15:0] sh_q;
  logic [4:0]  nbit_q;
  // junk power-up content, so only real writes can match
  initial regs_o = 64'ha5a5_a5a5_a5a5_a5a5;
  always @(negedge ser_load_n_i) nbit_q = 5'h00;
  always @(posedge ser_clk_i) begin
    if (!ser_load_n_i) begin
      sh_q = {sh_q[14:0], ser_data_i};
      nbit_q = nbit_q + 5'h01;
    end
  end
  // short or read frames are dropped, as the real part would
  always @(posedge ser_load_n_i) begin
    if (nbit_q == 5'h10 && !sh_q[15])
      regs_o[sh_q[14:12] * 8 +: 8] = sh_q[7:0];
  end
endmodule // ccd_adc_model

// file: verif/ccd_timing_monitor.sv
// assertion checker for the timing and converter setup block
`timescale 1ns/10ps
module ccd_timing_monitor #(
  parameter int LW = 13
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       still_mode_i,
  input wire logic       acquire_n_i,
  input wire logic [1:0] vertical_phase_clocks_o,
  input wire logic [1:0] horizontal_phase_clocks_o,
  input wire logic       pix_sync_o,
  input wire logic       frame_sync_o,
  input wire logic       integrate_o,
  input wire logic       flushing_o,
  input wire logic       ser_clk_o,
  input wire logic       ser_data_o,
  input wire logic       ser_load_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [9:0] lo_cnt_q;
  logic [9:0] vp_cnt_q;
  always_ff @(posedge clk_sys_i) begin
    lo_cnt_q <= ser_load_n_o ? 10'h000 : lo_cnt_q + 10'h001;
  end
  always_ff @(posedge clk_sys_i) begin
    vp_cnt_q <= vertical_phase_clocks_o[1] ? vp_cnt_q + 10'h001 : 10'h000;
  end
  sequence s_sclk_high;
    ser_clk_o [*5] ##1 !ser_clk_o;
  endsequence
  a_sclk_half: assert property ($rose(ser_clk_o) |-> s_sclk_high)
    else $error("serial clock high half is not five cycles");
  a_frame_len: assert property ($rose(ser_load_n_o) |-> lo_cnt_q == 10'h0a0)
    else $error("load window is not 160 cycles");
  a_sclk_idle: assert property (ser_load_n_o |-> !ser_clk_o)
    else $error("serial clock moves outside a frame");
  a_data_stable: assert property ($rose(ser_clk_o) |-> $stable(ser_data_o))
    else $error("serial data moves at the clock rise");
  a_pix_period: assert property (pix_sync_o |=> !pix_sync_o [*7])
    else $error("pixel pulses closer than eight cycles");
  a_vpulse_width: assert property ($fell(vertical_phase_clocks_o[1]) |-> vp_cnt_q == 10'h200)
    else $error("vertical pulse is not 64 pixel counts");
  a_h_quiet: assert property (vertical_phase_clocks_o[1] |-> horizontal_phase_clocks_o == 2'b00)
    else $error("horizontal clocks run in the vertical pulse");
  a_one_state: assert property ($onehot0({flushing_o, integrate_o, frame_sync_o}))
    else $error("two sequencer phases at once");
  a_trig_flush: assert property (still_mode_i && $past(still_mode_i) && $fell(acquire_n_i) && !flushing_o && !integrate_o && !frame_sync_o |-> ##[1:3] flushing_o)
    else $error("trigger in idle did not start a flush");
endmodule // ccd_timing_monitor

bind ccd_timing_top ccd_timing_monitor #(.LW(LW)) u_mon (
  .clk_sys_i, .rst_i, .still_mode_i, .acquire_n_i,
  .vertical_phase_clocks_o, .horizontal_phase_clocks_o, .pix_sync_o,
  .frame_sync_o, .integrate_o, .flushing_o,
  .ser_clk_o, .ser_data_o, .ser_load_n_o
);

// file: verif/ccd_timing_adc_setup_bench.sv
// self-checking bench for the timing and converter setup block
`timescale 1ns/10ps
module ccd_timing_adc_setup_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic still = 1'b0;
  logic prog = 1'b1;
  logic [5:0] units = 6'h02;
  logic acq_n = 1'b1;
  logic int_clk = 1'b0;
  logic [2:0] adj_addr = 3'h0;
  logic [7:0] adj_data = 8'h00;
  logic [1:0] vph, hph;
  logic pix, line, frame, integ, flush, sclk, sdat, sload_n, busy;
  logic [63:0] regs;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int k, n;
  int n_cyc, n_line, n_vp, n_hp;
  logic fl_seen;

  always #5 clk_sys_i = ~clk_sys_i;
  // integration clock far faster than nominal to keep the run short
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc % 20 == 19) int_clk <= #1 ~int_clk;
    if (cyc == 30000) begin
      n_mismatch++;
      test_done();
    end
  end

  ccd_timing_top #(.LW(13)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .still_mode_i(still),
    .acquire_n_i(acq_n), .int_clk_i(int_clk), .int_units_i(units),
    .pix_per_line_i(13'h0004), .lines_per_frame_i(13'h0002),
    .prog_internal_i(prog), .adj_addr_i(adj_addr), .adj_data_i(adj_data),
    .vertical_phase_clocks_o(vph), .horizontal_phase_clocks_o(hph),
    .pix_sync_o(pix), .line_sync_o(line), .frame_sync_o(frame),
    .integrate_o(integ), .flushing_o(flush), .ser_clk_o(sclk),
    .ser_data_o(sdat), .ser_load_n_o(sload_n), .adc_busy_o(busy));
  ccd_adc_model u_adc (.ser_clk_i(sclk), .ser_data_i(sdat),
    .ser_load_n_i(sload_n), .regs_o(regs));

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wait_frame(logic v);
    k = 0;
    while (frame !== v && k < 9000) begin
      fl_seen |= flush;
      tick(1);
      k++;
    end
    if (k == 9000) n_mismatch++;
  endtask
  function automatic logic [7:0] exp_val(logic [2:0] a, logic [7:0] d);
    return (a == 3'h0) ? (d & 8'h3e) : d; // test bits 7, 6, 0 forced low
  endfunction
  function automatic logic [7:0] exp_boot(int a);
    case (a)
      0: return 8'h20 | 8'h10 | 8'h02; // cds, 3 v span, one channel
      1: return 8'h08 | 8'h01; // green, fixed bit 0
      default: return 8'h00; // unity gain, zero offset
    endcase
  endfunction
  task automatic adjust(logic [2:0] a, logic [7:0] d);
    adj_addr = a;
    adj_data = d;
    acq_n = 1'b0;
    tick(2);
    acq_n = 1'b1;
    tick(20);
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      tick(1);
      k++;
    end
    check("adjusted reg", regs[a * 8 +: 8], exp_val(a, d));
  endtask

  task automatic check_boot();
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      tick(1);
      k++;
    end
    for (int a = 0; a < 8; a++)
      check("boot reg", regs[a * 8 +: 8], exp_boot(a));
  endtask

  initial begin
    void'($urandom(49309));
    fl_seen = 1'b0;
    tick(16);
    rst_i = 1'b0;
    // free-run from the start, so this first trigger cannot start a flush
    adjust(3'h0, 8'h32); // power-up load and this resend share address 0
    check_boot();
    still = 1'b0;
    wait_frame(1'b0); // count from a frame boundary, not mid-frame
    wait_frame(1'b1);
    n = 0;
    n_cyc = 0;
    n_line = 0;
    n_vp = 0;
    n_hp = 0;
    while (frame === 1'b1 && k < 9000) begin
      n += (pix === 1'b1);
      n_cyc += 1;
      n_line += (line === 1'b1 && vph === 2'b01);
      n_vp += (vph === 2'b10);
      n_hp += (hph === 2'b10);
      fl_seen |= flush;
      tick(1);
      k++;
    end
    check("pixels per frame", 16'(n), 16'h0008);
    // two lines of (64 + 4) pixels, eight cycles each
    check("frame cycles", 16'(n_cyc), 16'h0440);
    check("vertical pulse", 16'(n_vp), 16'h0400);
    check("line sync", 16'(n_line), 16'h0040);
    check("h1 high", 16'(n_hp), 16'h0020);
    n = 0;
    while (integ === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check("integration span", 16'(n > 38 && n < 86), 16'h0001);
    units = 6'h00; // zero units: integration shrinks to one cycle
    wait_frame(1'b0);
    n = 0;
    while (integ === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check("zero units", 16'(n), 16'h0001);
    units = 6'h02;
    adjust(3'h0, 8'hff);
    adjust(3'h5, 8'hff);
    adjust(3'h5, 8'h7f);
    adjust(3'h2, 8'h00);
    repeat (6) adjust(3'($urandom), 8'($urandom));
    prog = 1'b0; // strap low: a trigger must send nothing
    adj_addr = 3'h3;
    adj_data = 8'h5a;
    acq_n = 1'b0;
    tick(2);
    acq_n = 1'b1;
    tick(20);
    check("strap low quiet", 16'({busy, sload_n}), 16'h0001);
    prog = 1'b1;
    check("free-run flush", 16'(fl_seen), 16'h0000);
    still = 1'b1;
    wait_frame(1'b1);
    wait_frame(1'b0);
    tick(3);
    acq_n = 1'b0;
    tick(4);
    check("flush start", 16'(flush), 16'h0001);
    acq_n = 1'b1;
    tick(1500);
    adjust(3'h6, 8'h80); // trigger mid-flush: loads, no restart
    check("still flushing", 16'({flush, frame}), 16'h0002);
    rst_i = 1'b1; // reset cuts the flush; the reload must repeat
    tick(2);
    rst_i = 1'b0;
    tick(2);
    check("idle after reset", 16'({flush, integ, frame}), 16'h0000);
    check_boot();
    test_done();
  end
endmodule // ccd_timing_adc_setup_bench
